// ---- include/led_bank_regs.svh ----
`ifndef LED_BANK_REGS_SVH
`define LED_BANK_REGS_SVH

// Register offsets of the two bank registers.
`define LB_OFF_BANK_THREE   8'h04
`define LB_OFF_BANK_FOUR    8'h05
// Field layout inside a bank register.
`define LB_FADE_BIT         5
`define LB_CODE_MSB         4
`define LB_WRITE_MASK       8'h3f
`define LB_RESET_VALUE      8'h00
// Fade ramp step time and blink half period.
`define LB_CLK_PERIOD_NS    10
`define LB_FADE_STEP_NS     1000
`define LB_FADE_STEP_CYCLES ((`LB_FADE_STEP_NS + `LB_CLK_PERIOD_NS - 1) / `LB_CLK_PERIOD_NS)
`define LB_BLINK_TICKS      256

`endif

// ---- include/led_bank_pkg.sv ----
package led_bank_pkg;

	typedef enum logic [2:0] {
		I2C_IDLE,
		I2C_ADDR,
		I2C_PTR,
		I2C_WDATA,
		I2C_RDATA,
		I2C_ACK_OUT,
		I2C_ACK_IN
	} i2cState_t;

	typedef struct packed {
		logic       ledOn;
		logic       fadeEnable;
		logic       blinkBreatheEnable;
		logic [4:0] code;
		logic [4:0] targetCode;
	} bankCtrl_t;

	typedef struct packed {
		logic [8:0] level;
		logic       phase;
		logic [7:0] blinkCnt;
	} chanState_t;

	typedef struct packed {
		i2cState_t  st;
		i2cState_t  afterAck;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic       sclPrev;
		logic       sdaPrev;
		logic       sdaOe;
		logic       sdaOut;
		logic [7:0] bankThree;
		logic [7:0] bankFour;
		logic [6:0] tickCnt;
		logic       rampTick;
	} topState_t;

endpackage : led_bank_pkg

// ---- src/led_bank_channel.sv ----
`timescale 1ns/1ps
`include "led_bank_regs.svh"

module led_bank_channel (
	input  wire logic                   clk_sys,   // System clock.
	input  wire logic                   rst_b,     // Asynchronous reset, active low.
	input  wire logic                   rampTick,  // One-cycle fade step enable.
	input  wire led_bank_pkg::bankCtrl_t ctrl,     // Bank settings.
	output logic [8:0]                  sinkLevel  // Sink current in 0.05 mA units.
);

	led_bank_pkg::chanState_t s_q;
	led_bank_pkg::chanState_t s_d;
	logic [8:0]               bankLevel;
	logic [8:0]               targetLevel;
	logic [8:0]               goal;
	logic                     effectOn;

	// Current table in units of 0.05 mA, so every entry is an exact integer.
	function automatic logic [8:0] decodeCurrent(input logic [4:0] code);
		logic [8:0] c;
		c = {4'h0, code};
		if (code < 5'h05)
		begin
			case (code[2:0])
				3'h0:    decodeCurrent = 9'h000;
				3'h1:    decodeCurrent = 9'h001;
				3'h2:    decodeCurrent = 9'h002;
				3'h3:    decodeCurrent = 9'h004;
				default: decodeCurrent = 9'h00a;
			endcase
		end
		else if (code < 5'h0e)
			decodeCurrent = 9'h014 + (c - 9'h005) * 9'h00a;
		else if (code < 5'h1e)
			decodeCurrent = 9'h078 + (c - 9'h00e) * 9'h014;
		else
			decodeCurrent = code[0] ? 9'h1f4 : 9'h1cc;
	endfunction : decodeCurrent

	always_comb
	begin
		s_d         = s_q;
		bankLevel   = ctrl.ledOn ? decodeCurrent(ctrl.code) : 9'h000;
		targetLevel = decodeCurrent(ctrl.targetCode);
		effectOn    = ctrl.blinkBreatheEnable && ctrl.ledOn;
		goal        = (effectOn && s_q.phase) ? targetLevel : bankLevel;
		if (!ctrl.fadeEnable && !effectOn)
			s_d.level = bankLevel;
		else if (!ctrl.fadeEnable)
		begin
			s_d.level = goal;
			if (rampTick)
			begin
				if (s_q.blinkCnt == 8'(`LB_BLINK_TICKS - 1))
				begin
					s_d.blinkCnt = 8'h00;
					s_d.phase    = ~s_q.phase;
				end
				else
					s_d.blinkCnt = s_q.blinkCnt + 8'h01;
			end
		end
		else if (rampTick)
		begin
			// Fade and breathe move one table unit per step, never a jump.
			if (s_q.level < goal)
				s_d.level = s_q.level + 9'h001;
			else if (s_q.level > goal)
				s_d.level = s_q.level - 9'h001;
			else if (effectOn)
				s_d.phase = ~s_q.phase;
		end
		if (!effectOn)
		begin
			s_d.phase    = 1'b0;
			s_d.blinkCnt = 8'h00;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign sinkLevel = s_q.level;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	property p_offWhenDisabled;
		!ctrl.ledOn && !ctrl.fadeEnable |=> sinkLevel == 9'h000;
	endproperty
	a_offWhenDisabled: assert property (p_offWhenDisabled) else $error("disabled bank still sinks");

	property p_zeroCodeOff;
		ctrl.code == 5'h00 && !ctrl.blinkBreatheEnable && !ctrl.fadeEnable |=> sinkLevel == 9'h000;
	endproperty
	a_zeroCodeOff: assert property (p_zeroCodeOff) else $error("zero code did not switch bank off");

	property p_stepApply;
		ctrl.ledOn && !ctrl.fadeEnable && !ctrl.blinkBreatheEnable |=> sinkLevel == decodeCurrent($past(ctrl.code));
	endproperty
	a_stepApply: assert property (p_stepApply) else $error("plain code not applied in one step");

	property p_fadeBounded;
		ctrl.fadeEnable |=> (sinkLevel <= $past(sinkLevel) + 9'h001) && (sinkLevel + 9'h001 >= $past(sinkLevel));
	endproperty
	a_fadeBounded: assert property (p_fadeBounded) else $error("fade jumped more than one unit");

	property p_fadeHoldOffTick;
		ctrl.fadeEnable && !rampTick |=> $stable(sinkLevel);
	endproperty
	a_fadeHoldOffTick: assert property (p_fadeHoldOffTick) else $error("fade moved without a step");

	property p_blinkToggle;
		ctrl.blinkBreatheEnable && ctrl.ledOn && !ctrl.fadeEnable && rampTick
			&& s_q.blinkCnt == 8'(`LB_BLINK_TICKS - 1) |=> s_q.phase != $past(s_q.phase);
	endproperty
	a_blinkToggle: assert property (p_blinkToggle) else $error("blink loop did not toggle");

	c_blink: cover property (ctrl.blinkBreatheEnable && !ctrl.fadeEnable && $changed(s_q.phase));
	c_fadeUp: cover property (ctrl.fadeEnable && sinkLevel > $past(sinkLevel));

endmodule : led_bank_channel

// ---- src/led_bank_current_effect_regs.sv ----
// Operation
// - Register 04h holds bank three code, fade.
// - Register 05h holds bank four, same layout.
// - Cleared sink enables switch bank off always.
// - Zero code off only without blink/breathe.
// - Bank three effect from fade plus 08h.
// - Bank four effect from fade plus 09h.
// - Fade ramps on code change, enable, disable.
// - Blink and breathe loop until disabled.
// - All bank sinks share one code current.
// - Five-bit code decodes through nonlinear table.
// - Effect target from target register code.
`timescale 1ns/1ps
`include "led_bank_regs.svh"

module led_bank_current_effect_regs #(
	parameter logic [6:0] DEV_ADDR = 7'h2a  // Bus address; value is arbitrary.
) (
	input  wire logic       clk_sys,                       // System clock, 100 MHz.
	input  wire logic       rst_b,                         // Asynchronous reset, active low.
	input  wire logic       sclIn,                         // Serial clock pin level.
	input  wire logic       sdaIn,                         // Serial data pin level.
	output logic            sdaOut,                        // Serial data drive value, always low.
	output logic            sdaOe,                         // Serial data pulled low while high.
	input  wire logic       bankThreeSinksEnabled,         // Any bank three sink enabled.
	input  wire logic       bankFourSinksEnabled,          // Any bank four sink enabled.
	input  wire logic       bankThreeBlinkBreatheEnable,   // Bank three blink/breathe enable.
	input  wire logic       bankFourBlinkBreatheEnable,    // Bank four blink/breathe enable.
	input  wire logic [4:0] bankThreeTargetCode,           // Bank three effect target code.
	input  wire logic [4:0] bankFourTargetCode,            // Bank four effect target code.
	output logic [8:0]      bankThreeLevel,                // Bank three sink current, 0.05 mA units.
	output logic [8:0]      bankFourLevel                  // Bank four sink current, 0.05 mA units.
);

	led_bank_pkg::topState_t s_q;
	led_bank_pkg::topState_t s_d;
	led_bank_pkg::bankCtrl_t threeCtrl;
	led_bank_pkg::bankCtrl_t fourCtrl;
	logic                    sclRise;
	logic                    sclFall;
	logic                    startSeen;
	logic                    stopSeen;
	logic                    byteDone;
	logic                    writeStrobe;

	// Only the two bank registers live here; every other offset reads zero.
	function automatic logic [7:0] readReg(input logic [7:0] ptr, input logic [7:0] three,
		input logic [7:0] four);
		if (ptr == `LB_OFF_BANK_THREE)
			readReg = three;
		else if (ptr == `LB_OFF_BANK_FOUR)
			readReg = four;
		else
			readReg = 8'h00;
	endfunction : readReg

	assign sclRise     = sclIn && !s_q.sclPrev;
	assign sclFall     = !sclIn && s_q.sclPrev;
	assign startSeen   = sclIn && s_q.sclPrev && s_q.sdaPrev && !sdaIn;
	assign stopSeen    = sclIn && s_q.sclPrev && !s_q.sdaPrev && sdaIn;
	assign byteDone    = sclFall && s_q.bitCnt == 4'h8;
	assign writeStrobe = byteDone && s_q.st == led_bank_pkg::I2C_WDATA;

	always_comb
	begin
		s_d          = s_q;
		s_d.sclPrev  = sclIn;
		s_d.sdaPrev  = sdaIn;
		s_d.sdaOut   = 1'b0;
		s_d.rampTick = 1'b0;
		if (s_q.tickCnt == 7'(`LB_FADE_STEP_CYCLES - 1))
		begin
			s_d.tickCnt  = 7'h00;
			s_d.rampTick = 1'b1;
		end
		else
			s_d.tickCnt = s_q.tickCnt + 7'h01;

		if (startSeen)
		begin
			s_d.st     = led_bank_pkg::I2C_ADDR;
			s_d.bitCnt = 4'h0;
			s_d.sdaOe  = 1'b0;
		end
		else if (stopSeen)
		begin
			s_d.st    = led_bank_pkg::I2C_IDLE;
			s_d.sdaOe = 1'b0;
		end
		else
		begin
			case (s_q.st)
				led_bank_pkg::I2C_ADDR, led_bank_pkg::I2C_PTR, led_bank_pkg::I2C_WDATA:
				begin
					if (sclRise)
					begin
						s_d.shift  = {s_q.shift[6:0], sdaIn};
						s_d.bitCnt = s_q.bitCnt + 4'h1;
					end
					else if (byteDone)
					begin
						s_d.bitCnt   = 4'h0;
						s_d.sdaOe    = 1'b1;
						s_d.st       = led_bank_pkg::I2C_ACK_OUT;
						s_d.afterAck = led_bank_pkg::I2C_WDATA;
						if (s_q.st == led_bank_pkg::I2C_ADDR)
						begin
							if (s_q.shift[7:1] != DEV_ADDR)
							begin
								s_d.sdaOe = 1'b0;
								s_d.st    = led_bank_pkg::I2C_IDLE;
							end
							else if (s_q.shift[0])
							begin
								s_d.afterAck = led_bank_pkg::I2C_RDATA;
								s_d.shift    = readReg(s_q.ptr, s_q.bankThree, s_q.bankFour);
							end
							else
								s_d.afterAck = led_bank_pkg::I2C_PTR;
						end
						else if (s_q.st == led_bank_pkg::I2C_PTR)
							s_d.ptr = s_q.shift;
						else
						begin
							// Bits 7:6 are reserved and always read back as zero.
							if (s_q.ptr == `LB_OFF_BANK_THREE)
								s_d.bankThree = s_q.shift & `LB_WRITE_MASK;
							if (s_q.ptr == `LB_OFF_BANK_FOUR)
								s_d.bankFour = s_q.shift & `LB_WRITE_MASK;
							s_d.ptr = s_q.ptr + 8'h01;
						end
					end
				end
				led_bank_pkg::I2C_ACK_OUT:
				begin
					if (sclFall)
					begin
						s_d.st     = s_q.afterAck;
						s_d.bitCnt = 4'h0;
						s_d.sdaOe  = (s_q.afterAck == led_bank_pkg::I2C_RDATA) ? !s_q.shift[7] : 1'b0;
					end
				end
				led_bank_pkg::I2C_RDATA:
				begin
					if (sclRise)
						s_d.bitCnt = s_q.bitCnt + 4'h1;
					else if (byteDone)
					begin
						s_d.sdaOe = 1'b0;
						s_d.st    = led_bank_pkg::I2C_ACK_IN;
					end
					else if (sclFall)
					begin
						s_d.shift = {s_q.shift[6:0], 1'b0};
						s_d.sdaOe = !s_q.shift[6];
					end
				end
				led_bank_pkg::I2C_ACK_IN:
				begin
					if (sclRise)
					begin
						// A missing acknowledge ends the read; the master then sends a stop.
						if (sdaIn)
							s_d.st = led_bank_pkg::I2C_IDLE;
						else
						begin
							s_d.ptr      = s_q.ptr + 8'h01;
							s_d.shift    = readReg(s_q.ptr + 8'h01, s_q.bankThree, s_q.bankFour);
							s_d.st       = led_bank_pkg::I2C_ACK_OUT;
							s_d.afterAck = led_bank_pkg::I2C_RDATA;
						end
					end
				end
				led_bank_pkg::I2C_IDLE:
					s_d.sdaOe = 1'b0;
				default:
				begin
					s_d.st    = led_bank_pkg::I2C_IDLE;
					s_d.sdaOe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_q           <= '0;
			s_q.sclPrev   <= 1'b1;
			s_q.sdaPrev   <= 1'b1;
			s_q.bankThree <= `LB_RESET_VALUE;
			s_q.bankFour  <= `LB_RESET_VALUE;
		end
		else
			s_q <= s_d;
	end

	assign sdaOut = s_q.sdaOut;
	assign sdaOe  = s_q.sdaOe;

	always_comb
	begin
		threeCtrl.ledOn              = bankThreeSinksEnabled;
		threeCtrl.fadeEnable         = s_q.bankThree[`LB_FADE_BIT];
		threeCtrl.blinkBreatheEnable = bankThreeBlinkBreatheEnable;
		threeCtrl.code               = s_q.bankThree[`LB_CODE_MSB:0];
		threeCtrl.targetCode         = bankThreeTargetCode;
		fourCtrl.ledOn               = bankFourSinksEnabled;
		fourCtrl.fadeEnable          = s_q.bankFour[`LB_FADE_BIT];
		fourCtrl.blinkBreatheEnable  = bankFourBlinkBreatheEnable;
		fourCtrl.code                = s_q.bankFour[`LB_CODE_MSB:0];
		fourCtrl.targetCode          = bankFourTargetCode;
	end

	led_bank_channel u_three (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.rampTick  (s_q.rampTick),
		.ctrl      (threeCtrl),
		.sinkLevel (bankThreeLevel)
	);

	led_bank_channel u_four (
		.clk_sys   (clk_sys),
		.rst_b     (rst_b),
		.rampTick  (s_q.rampTick),
		.ctrl      (fourCtrl),
		.sinkLevel (bankFourLevel)
	);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	property p_writeThree;
		writeStrobe && s_q.ptr == `LB_OFF_BANK_THREE |=> s_q.bankThree == ($past(s_q.shift) & `LB_WRITE_MASK);
	endproperty
	a_writeThree: assert property (p_writeThree) else $error("bank three write lost");

	property p_writeFour;
		writeStrobe && s_q.ptr == `LB_OFF_BANK_FOUR |=> s_q.bankFour == ($past(s_q.shift) & `LB_WRITE_MASK);
	endproperty
	a_writeFour: assert property (p_writeFour) else $error("bank four write lost");

	property p_tickSpacing;
		s_q.rampTick |=> !s_q.rampTick [*8];
	endproperty
	a_tickSpacing: assert property (p_tickSpacing) else $error("fade steps too close");

	c_writeThree: cover property (writeStrobe && s_q.ptr == `LB_OFF_BANK_THREE);
	c_readByte: cover property (s_q.st == led_bank_pkg::I2C_ACK_IN && sclRise);

endmodule : led_bank_current_effect_regs

// ---- bench/i2c_host_model.sv ----
`timescale 1ns/1ps

module i2c_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2a  // Device address to call; value is arbitrary.
) (
	input  wire logic clk_sys,    // System clock.
	input  wire logic sdaLine,    // Resolved data line level.
	output logic      scl,        // Serial clock drive.
	output logic      sdaPullLow  // High while the host pulls data low.
);
	// Third-of-a-bit length in clocks (each bit is three Q phases), well clear of the device's two-sample start filter.
	localparam int Q = 4;

	initial
	begin
		scl = 1'b1;
		sdaPullLow = 1'b0;
	end

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : idle

	// Data only moves while the clock is low, so no false start or stop is seen.
	task automatic putBit(input logic b);
		sdaPullLow <= !b;
		idle(Q);
		scl <= 1'b1;
		idle(Q);
		scl <= 1'b0;
		idle(Q);
	endtask : putBit

	task automatic getBit(output logic b);
		sdaPullLow <= 1'b0;
		idle(Q);
		scl <= 1'b1;
		idle(Q);
		b = sdaLine;
		scl <= 1'b0;
		idle(Q);
	endtask : getBit

	// Also serves as repeated start when entered with the clock low.
	task automatic start();
		sdaPullLow <= 1'b0;
		idle(Q);
		scl <= 1'b1;
		idle(Q);
		sdaPullLow <= 1'b1;
		idle(Q);
		scl <= 1'b0;
		idle(Q);
	endtask : start

	task automatic stop();
		sdaPullLow <= 1'b1;
		idle(Q);
		scl <= 1'b1;
		idle(Q);
		sdaPullLow <= 1'b0;
		idle(Q);
	endtask : stop

	task automatic putByte(input logic [7:0] v, inout logic ack);
		logic a;
		for (int i = 7; i >= 0; i--)
			putBit(v[i]);
		getBit(a);
		ack = ack & !a;
	endtask : putByte

	task automatic writeReg(input logic [7:0] off, input logic [7:0] d0, input logic [7:0] d1,
		input logic two, output logic ack);
		ack = 1'b1;
		start();
		putByte({DEV_ADDR, 1'b0}, ack);
		putByte(off, ack);
		putByte(d0, ack);
		if (two)
			putByte(d1, ack);
		stop();
	endtask : writeReg

	task automatic readReg(input logic [7:0] off, output logic [7:0] data, output logic ack);
		ack = 1'b1;
		start();
		putByte({DEV_ADDR, 1'b0}, ack);
		putByte(off, ack);
		start();
		putByte({DEV_ADDR, 1'b1}, ack);
		for (int i = 7; i >= 0; i--)
			getBit(data[i]);
		putBit(1'b1);
		stop();
	endtask : readReg
endmodule : i2c_host_model

// ---- bench/test_led_bank_current_effect_regs.sv ----
`timescale 1ns/1ps

module test_led_bank_current_effect_regs;
	localparam logic [6:0] ADDR = 7'h2a;
	logic       clk_sys, rst_b, sclIn, sdaPullLow, sdaOut, sdaOe, sdaLine, ack;
	logic       threeEn, fourEn, threeBb, fourBb;
	logic [4:0] threeTgt, fourTgt;
	logic [8:0] threeLvl, fourLvl;
	logic [7:0] rd;
	int         n_mismatch, num_checks, cycles, c;

	// Open-drain data line with a pull-up.
	assign sdaLine = !(sdaPullLow || sdaOe);

	led_bank_current_effect_regs #(.DEV_ADDR(ADDR)) led_bank_current_effect_regs_i (
		.clk_sys(clk_sys), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaLine), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .bankThreeSinksEnabled(threeEn), .bankFourSinksEnabled(fourEn),
		.bankThreeBlinkBreatheEnable(threeBb), .bankFourBlinkBreatheEnable(fourBb),
		.bankThreeTargetCode(threeTgt), .bankFourTargetCode(fourTgt),
		.bankThreeLevel(threeLvl), .bankFourLevel(fourLvl));

	i2c_host_model #(.DEV_ADDR(ADDR)) i2c_host_model_i (
		.clk_sys(clk_sys), .sdaLine(sdaLine), .scl(sclIn), .sdaPullLow(sdaPullLow));

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	function automatic logic [8:0] units(input logic [4:0] k);
		case (k)
			5'h00: return 9'h000;
			5'h01: return 9'h001;
			5'h02: return 9'h002;
			5'h03: return 9'h004;
			5'h04: return 9'h00a;
			5'h1e: return 9'h1cc;
			5'h1f: return 9'h1f4;
			default: return (k < 5'h0e) ? 9'h014 + 9'(k - 5'h05) * 9'h00a : 9'h078 + 9'(k - 5'h0e) * 9'h014;
		endcase
	endfunction : units

	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : settle

	// Levels are sampled on the falling edge, away from register updates.
	task automatic waitLevel(input string what, input logic four, input logic [8:0] goal, input int limit);
		for (int i = 0; i < limit && (four ? fourLvl : threeLvl) !== goal; i++)
			@(negedge clk_sys);
		check(what, four ? fourLvl : threeLvl, goal);
		@(posedge clk_sys);
	endtask : waitLevel

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 95000)
		begin
			n_mismatch++;
			final_report();
		end
	end

	initial
	begin
		rst_b = 1'b0;
		{threeEn, fourEn, threeBb, fourBb} = 4'h0;
		threeTgt = 5'h00;
		fourTgt = 5'h00;
		settle(12);
		rst_b <= 1'b1;
		settle(1);
		i2c_host_model_i.readReg(8'h04, rd, ack);
		check("reset three", {1'b0, rd}, 9'h000);
		i2c_host_model_i.readReg(8'h05, rd, ack);
		check("reset four", {1'b0, rd}, 9'h000);
		check("read ack", {8'h00, ack}, 9'h001);
		$display("test reset done");

		threeEn <= 1'b1;
		fourEn <= 1'b1;
		for (c = 0; c < 32; c++)
		begin
			i2c_host_model_i.writeReg(8'h04, {3'b000, 5'(c)}, {3'b000, 5'(31 - c)}, 1'b1, ack);
			settle(3);
			check("write ack", {8'h00, ack}, 9'h001);
			check("three level", threeLvl, units(5'(c)));
			check("four level", fourLvl, units(5'(31 - c)));
		end
		$display("test decode done");

		i2c_host_model_i.writeReg(8'h04, 8'hdf, 8'h00, 1'b0, ack);
		i2c_host_model_i.readReg(8'h04, rd, ack);
		check("three fields", {1'b0, rd}, 9'h01f);
		i2c_host_model_i.writeReg(8'h05, 8'he0, 8'h00, 1'b0, ack);
		i2c_host_model_i.readReg(8'h05, rd, ack);
		check("four fields", {1'b0, rd}, 9'h020);
		i2c_host_model_i.writeReg(8'h06, 8'h15, 8'h00, 1'b0, ack);
		i2c_host_model_i.readReg(8'h06, rd, ack);
		check("unmapped", {1'b0, rd}, 9'h000);
		i2c_host_model_i.writeReg(8'h04, 8'h00, 8'h00, 1'b0, ack);
		settle(3);
		check("zero code off", threeLvl, 9'h000);
		$display("test fields done");

		i2c_host_model_i.writeReg(8'h04, 8'h0d, 8'h00, 1'b0, ack);
		settle(3);
		check("step", threeLvl, 9'h064);
		threeEn <= 1'b0;
		settle(3);
		check("sinks off", threeLvl, 9'h000);
		threeEn <= 1'b1;
		settle(3);
		check("sinks on", threeLvl, 9'h064);
		$display("test sinks done");

		i2c_host_model_i.writeReg(8'h04, 8'h05, 8'h00, 1'b0, ack);
		settle(3);
		check("low step", threeLvl, 9'h014);
		i2c_host_model_i.writeReg(8'h04, 8'h29, 8'h00, 1'b0, ack);
		settle(300);
		check("ramp up", {8'h00, threeLvl > 9'h014 && threeLvl < 9'h03c}, 9'h001);
		waitLevel("fade top", 1'b0, 9'h03c, 5000);
		threeEn <= 1'b0;
		settle(300);
		check("ramp down", {8'h00, threeLvl > 9'h000 && threeLvl < 9'h03c}, 9'h001);
		waitLevel("fade off", 1'b0, 9'h000, 7000);
		$display("test fade done");

		i2c_host_model_i.writeReg(8'h04, 8'h20, 8'h00, 1'b0, ack);
		threeEn <= 1'b1;
		threeTgt <= 5'h07;
		threeBb <= 1'b1;
		fourTgt <= 5'h1f;
		waitLevel("breathe top", 1'b0, 9'h028, 5000);
		check("four idle", fourLvl, 9'h000);
		waitLevel("breathe low", 1'b0, 9'h000, 5000);
		waitLevel("breathe again", 1'b0, 9'h028, 5000);
		fourTgt <= 5'h03;
		fourBb <= 1'b1;
		waitLevel("four breathe", 1'b1, 9'h004, 1000);
		$display("test effects done");

		// Dropping the effect first clears the blink counter, so the half period starts from zero.
		fourBb <= 1'b0;
		i2c_host_model_i.writeReg(8'h05, 8'h0d, 8'h00, 1'b0, ack);
		settle(3);
		check("four step", fourLvl, 9'h064);
		fourBb <= 1'b1;
		settle(20000);
		check("blink hold", fourLvl, 9'h064);
		waitLevel("blink target", 1'b1, 9'h004, 7000);
		fourEn <= 1'b0;
		settle(3);
		check("four sinks off", fourLvl, 9'h000);
		check("sda drive", {8'h00, sdaOut}, 9'h000);
		$display("test blink done");
		final_report();
	end
endmodule : test_led_bank_current_effect_regs
